//--- plm_exec.v
// Executor for the pointer literal load and file register move instructions
`timescale 1ns/1ns
`include "plm_regs.vh"

module plm_exec (
  input wire sys_clk,
  input wire rst_n,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output wire exec_busy,
  output wire [7:0] accumulator
);

  // ****************************************************************
  // State
  // ****************************************************************
  reg [15:0] instr_reg;
  reg [1:0] kind_reg;
  reg [13:0] eff_addr_reg;
  reg [7:0] result_reg;
  reg [7:0] acc_reg;
  reg [5:0] bank_reg;
  reg ext_reg;
  reg zero_reg;
  reg msb_reg;
  reg pend_reg;
  reg [1:0] sel_reg;
  reg [3:0] hi_lit_reg;
  reg [13:0] daddr_reg;
  reg [1:0] rd_cnt_reg;
  wire [13:0] ptr [0:2];

  wire running;
  wire [1:0] phase;
  wire [7:0] dmem_q;
  wire wr_en = avs_write & (|avs_byteenable);
  wire instr_wr = wr_en & (avs_address == `PLM_OFS_INSTR);
  wire start = instr_wr & ~running;
  wire last_phase = running & (phase == `PLM_PHASES);

  // ****************************************************************
  // Phase strobes
  // ****************************************************************
  // Q2 needs no strobe: the memory read is the address standing for one clock.
  wire q1 = running & (phase == 2'h0);
  wire q3 = running & (phase == 2'h2);
  wire q4 = last_phase;

  assign exec_busy = running;
  assign accumulator = acc_reg;

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  // Instruction writes stall until the last phase, so fetch paces execution.
  assign avs_waitrequest = (avs_read & (rd_cnt_reg != `PLM_RD_LAST))
                         | (instr_wr & ~last_phase);

  plm_phase u_phase (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(start),
    .running(running),
    .phase(phase)
  );

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Unknown words decode as a no-op yet still run all four phases.
  reg [1:0] kind_next;
  always @* begin
    kind_next = `PLM_K_NOP;
    if (pend_reg) begin
      if (instr_reg[15:10] == `PLM_OP_PTR_LO) begin
        kind_next = `PLM_K_PTR_LO;
      end else begin
        kind_next = `PLM_K_NOP;
      end
    end else if (instr_reg[15:8] == `PLM_OP_PTR_HI &&
                 instr_reg[7:6] == `PLM_OP_PTR_HI_PAD) begin
      kind_next = `PLM_K_PTR_HI;
    end else if (instr_reg[15:10] == `PLM_OP_MOVE) begin
      kind_next = `PLM_K_MOVE;
    end
  end

  // ****************************************************************
  // Move addressing
  // ****************************************************************
  wire [7:0] f_addr = instr_reg[7:0];
  wire acc_bit = instr_reg[8];
  wire dst_bit = instr_reg[9];
  reg [13:0] eff_addr_next;
  always @* begin
    if (acc_bit) begin
      eff_addr_next = {bank_reg, f_addr};
    end else if (ext_reg && f_addr <= `PLM_IDX_LIMIT) begin
      eff_addr_next = ptr[`PLM_IDX_PTR] + {6'h00, f_addr};
    end else if (f_addr < `PLM_ACC_SPLIT) begin
      eff_addr_next = {`PLM_ACC_LO_BANK, f_addr};
    end else begin
      eff_addr_next = {`PLM_ACC_HI_BANK, f_addr};
    end
  end

  // ****************************************************************
  // Instruction latch
  // ****************************************************************
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_reg <= 16'h0000;
    end else if (start) begin
      instr_reg <= avs_writedata[15:0];
    end
  end

  // ****************************************************************
  // Execution sequence
  // ****************************************************************
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      kind_reg <= `PLM_K_NOP;
      eff_addr_reg <= 14'h0000;
      sel_reg <= 2'h0;
      hi_lit_reg <= 4'h0;
    end else if (q1) begin
      kind_reg <= kind_next;
      eff_addr_reg <= eff_addr_next;
      if (kind_next == `PLM_K_PTR_HI) begin
        sel_reg <= instr_reg[5:4];
        hi_lit_reg <= instr_reg[3:0];
      end
    end
  end

  // ****************************************************************
  // Operand capture
  // ****************************************************************
  // Read data lag the address by a clock, so Q2 presents it and Q3 takes it.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_reg <= 8'h00;
    end else if (q3) begin
      result_reg <= dmem_q;
    end
  end

  // ****************************************************************
  // Pointer load pending
  // ****************************************************************
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= 1'b0;
    end else if (q4) begin
      // A second word that is not the low half abandons the pending load.
      pend_reg <= (kind_reg == `PLM_K_PTR_HI);
    end
  end

  // ****************************************************************
  // Pointer registers
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_ptr
      reg [13:0] ptr_reg;
      wire sel_hit = ({30'h00000000, sel_reg} == gi);
      // Pointers sit one word apart in the map; compared in 32 bits to keep widths whole.
      wire [31:0] slot_ofs = {24'h000000, `PLM_OFS_PTR0} + 32'h00000004 * gi;
      wire bus_hit = wr_en & ({24'h000000, avs_address} == slot_ofs);
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          ptr_reg <= `PLM_PTR_RST;
        end else if (q4 && sel_hit && kind_reg == `PLM_K_PTR_HI) begin
          ptr_reg[13:10] <= hi_lit_reg;
        end else if (q4 && sel_hit && kind_reg == `PLM_K_PTR_LO) begin
          ptr_reg[9:0] <= instr_reg[9:0];
        end else if (bus_hit && !running) begin
          ptr_reg <= avs_writedata[13:0];
        end
      end
      assign ptr[gi] = ptr_reg;
    end
  endgenerate

  // ****************************************************************
  // Accumulator, flags and software registers
  // ****************************************************************
  wire move_q4 = q4 & (kind_reg == `PLM_K_MOVE);
  // Software writes other than the instruction word are dropped while busy.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= `PLM_ACC_RST;
      bank_reg <= `PLM_BANK_RST;
      ext_reg <= 1'b0;
      zero_reg <= 1'b0;
      msb_reg <= 1'b0;
      daddr_reg <= 14'h0000;
    end else if (move_q4) begin
      // Execution changes flags only here; pointer loads and no-ops never touch them.
      zero_reg <= (result_reg == 8'h00);
      msb_reg <= result_reg[7];
      if (!dst_bit) begin
        acc_reg <= result_reg;
      end
    end else if (wr_en && !running) begin
      case (avs_address)
        `PLM_OFS_ACC: begin
          acc_reg <= avs_writedata[7:0];
        end
        `PLM_OFS_STATUS: begin
          zero_reg <= avs_writedata[`PLM_ST_ZERO];
          msb_reg <= avs_writedata[`PLM_ST_MSB];
        end
        `PLM_OFS_BANK: begin
          bank_reg <= avs_writedata[5:0];
        end
        `PLM_OFS_CTRL: begin
          ext_reg <= avs_writedata[`PLM_CTRL_EXT];
        end
        `PLM_OFS_DADDR: begin
          daddr_reg <= avs_writedata[13:0];
        end
        default: begin
          daddr_reg <= daddr_reg;
        end
      endcase
    end
  end

  // ****************************************************************
  // Data memory port
  // ****************************************************************
  // The executor owns the port while running; software reaches it only when idle.
  wire [13:0] dmem_addr = running ? eff_addr_reg : daddr_reg;
  wire dmem_we = running ? (move_q4 & dst_bit)
                         : (wr_en & (avs_address == `PLM_OFS_DDATA));
  wire [7:0] dmem_wdata = running ? result_reg : avs_writedata[7:0];

  plm_dmem u_dmem (
    .sys_clk(sys_clk),
    .addr(dmem_addr),
    .we(dmem_we),
    .wdata(dmem_wdata),
    .rdata(dmem_q)
  );

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Every read takes three cycles so the memory window shares one path.
  reg [31:0] rd_mux;
  always @* begin
    case (avs_address)
      `PLM_OFS_INSTR: rd_mux = {16'h0000, instr_reg};
      `PLM_OFS_ACC: rd_mux = {24'h000000, acc_reg};
      `PLM_OFS_STATUS: rd_mux = {29'h00000000, pend_reg, msb_reg, zero_reg};
      `PLM_OFS_BANK: rd_mux = {26'h0000000, bank_reg};
      `PLM_OFS_CTRL: rd_mux = {31'h00000000, ext_reg};
      `PLM_OFS_PTR0: rd_mux = {18'h00000, ptr[0]};
      `PLM_OFS_PTR1: rd_mux = {18'h00000, ptr[1]};
      `PLM_OFS_PTR2: rd_mux = {18'h00000, ptr[2]};
      `PLM_OFS_DADDR: rd_mux = {18'h00000, daddr_reg};
      `PLM_OFS_DDATA: rd_mux = {24'h000000, dmem_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_cnt_reg <= 2'h0;
    end else if (avs_read) begin
      if (rd_cnt_reg == `PLM_RD_LAST) begin
        rd_cnt_reg <= 2'h0;
      end else begin
        rd_cnt_reg <= rd_cnt_reg + 2'h1;
      end
    end else begin
      rd_cnt_reg <= 2'h0;
    end
  end

  // Read data load on the same edge that waitrequest falls, then hold until the next read.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && rd_cnt_reg == 2'h1) begin
      avs_readdata <= rd_mux;
    end
  end

endmodule

//--- plm_regs.vh
// Register offsets, field positions, reset values and opcodes of the pointer/move executor
`ifndef PLM_REGS_VH
`define PLM_REGS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PLM_OFS_INSTR 8'h00
`define PLM_OFS_ACC 8'h04
`define PLM_OFS_STATUS 8'h08
`define PLM_OFS_BANK 8'h0C
`define PLM_OFS_CTRL 8'h10
`define PLM_OFS_PTR0 8'h14
`define PLM_OFS_PTR1 8'h18
`define PLM_OFS_PTR2 8'h1C
`define PLM_OFS_DADDR 8'h20
`define PLM_OFS_DDATA 8'h24

// ****************************************************************
// Field positions
// ****************************************************************
`define PLM_ST_ZERO 0
`define PLM_ST_MSB 1
`define PLM_ST_PEND 2
`define PLM_CTRL_EXT 0

// ****************************************************************
// Reset values
// ****************************************************************
`define PLM_ACC_RST 8'h00
`define PLM_BANK_RST 6'h00
`define PLM_PTR_RST 14'h0000

// ****************************************************************
// Opcodes and addressing constants
// ****************************************************************
`define PLM_OP_PTR_HI 8'hEE
`define PLM_OP_PTR_HI_PAD 2'h0
`define PLM_OP_PTR_LO 6'h3C
`define PLM_OP_MOVE 6'h14
`define PLM_PTR_MAX 2'h2
`define PLM_IDX_LIMIT 8'h5F
`define PLM_ACC_SPLIT 8'h60
`define PLM_ACC_LO_BANK 6'h00
`define PLM_ACC_HI_BANK 6'h04
`define PLM_IDX_PTR 2

// ****************************************************************
// Execution kinds and timing
// ****************************************************************
`define PLM_K_NOP 2'h0
`define PLM_K_PTR_HI 2'h1
`define PLM_K_PTR_LO 2'h2
`define PLM_K_MOVE 2'h3
`define PLM_PHASES 2'h3
`define PLM_RD_LAST 2'h2

`endif

//--- plm_phase.v
// Four-phase instruction cycle sequencer
`timescale 1ns/1ns
`include "plm_regs.vh"

module plm_phase (
  input wire sys_clk,
  input wire rst_n,
  input wire start,
  output reg running,
  output reg [1:0] phase
);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      running <= 1'b0;
      phase <= 2'h0;
    end else if (running) begin
      phase <= phase + 2'h1;
      if (phase == `PLM_PHASES) begin
        running <= 1'b0;
      end
    end else if (start) begin
      running <= 1'b1;
      phase <= 2'h0;
    end
  end

endmodule

//--- plm_dmem.v
// Byte-wide data memory with registered read data
`timescale 1ns/1ns

module plm_dmem (
  input wire sys_clk,
  input wire [13:0] addr,
  input wire we,
  input wire [7:0] wdata,
  output reg [7:0] rdata
);

  reg [7:0] mem [0:16383];

  always @(posedge sys_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

//--- plm_prog_mem.sv
// Program memory model supplying instruction words to the executor
`timescale 1ns/1ns

module plm_prog_mem (
  input wire [3:0] pc,
  output reg [15:0] word
);
  // ********
  // Program image, in program order
  // ********
  always @* begin
    case (pc)
      4'h0: word = 16'hEE0F;
      4'h1: word = 16'hF3FF;
      4'h2: word = 16'hEE18;
      4'h3: word = 16'hF001;
      4'h4: word = 16'hEE20;
      4'h5: word = 16'hF3AB;
      4'h6: word = 16'h5110;
      4'h7: word = 16'h5310;
      4'h8: word = 16'h5022;
      4'h9: word = 16'h5085;
      4'hA: word = 16'h5005;
      4'hB: word = 16'h5060;
      // Selector 3 names no pointer, so the pair must change nothing
      4'hC: word = 16'hEE30;
      4'hD: word = 16'hF123;
      default: word = 16'h0000;
    endcase
  end
endmodule

//--- plm_exec_sva.sv
// Port-level checker for the pointer/move executor
`timescale 1ns/1ns

module plm_exec_sva (
  input wire sys_clk,
  input wire rst_n,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire exec_busy,
  input wire [7:0] accumulator
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ********
  // Bus timing and instruction cycle
  // ********
  read_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 avs_waitrequest
    ##1 !avs_waitrequest) else $error("read answer not in third cycle");
  reg_write_a: assert property (avs_write && avs_address != 8'h00 |-> !avs_waitrequest)
    else $error("register write stalled");
  instr_cycle_a: assert property ($rose(avs_write) && avs_address == 8'h00 |->
    avs_waitrequest && !exec_busy ##1 (exec_busy && avs_waitrequest)[*3]
    ##1 (exec_busy && !avs_waitrequest) ##1 !exec_busy) else $error("bad instruction cycle");
  busy_cause_a: assert property ($rose(exec_busy) |-> $past(avs_write)
    && $past(avs_address) == 8'h00) else $error("busy without instruction");
  acc_cause_a: assert property ($changed(accumulator) |->
    $past(exec_busy && !avs_waitrequest) || $past(avs_write && avs_address == 8'h04))
    else $error("accumulator changed outside final phase");
  acc_hold_a: assert property (exec_busy && avs_waitrequest |=> $stable(accumulator))
    else $error("accumulator changed before final phase");
  rdata_cause_a: assert property ($changed(avs_readdata) |-> $past(avs_read))
    else $error("read data changed without read");
  unmapped_a: assert property (avs_read && !avs_waitrequest && avs_address == 8'h30
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
endmodule

//--- plm_exec_tb_top.sv
// Self-checking testbench for the pointer/move executor
`timescale 1ns/1ns

module plm_exec_tb_top;
  reg sys_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] avs_address = 8'h00;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg [3:0] avs_byteenable = 4'hF;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire exec_busy;
  wire [7:0] accumulator;
  wire [15:0] rom_word;
  reg [3:0] pc = 4'h0;
  reg [31:0] rd;
  reg [7:0] k;
  integer errors = 0;
  integer checks = 0;

  always #5 sys_clk = ~sys_clk;

  plm_exec dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .exec_busy(exec_busy), .accumulator(accumulator));
  plm_prog_mem prog_u (.pc(pc), .word(rom_word));

  // ********
  // Bus tasks
  // ********
  task summarize;
    begin
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] exp, input [31:0] got);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("wrong value at %0t: expected %h got %h", $time, exp, got);
      end
    end
  endtask
  // Waitrequest is sampled before this edge's updates land, as the slave sees it
  task xfer(input [7:0] a, input [31:0] d, input w);
    begin
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      xfer(a, d, 1'b1);
    end
  endtask
  task rdc(input [7:0] a, input [31:0] exp);
    begin
      @(posedge sys_clk);
      xfer(a, 32'h0, 1'b0);
      chk(exp, rd);
    end
  endtask
  task exec(input [3:0] i);
    begin
      pc = i;
      @(posedge sys_clk);
      xfer(8'h00, {16'h0000, rom_word}, 1'b1);
    end
  endtask
  task mset(input [13:0] a, input [7:0] b);
    begin
      wr(8'h20, {18'h0, a});
      wr(8'h24, {24'h0, b});
    end
  endtask

  // ********
  // Scenarios
  // ********
  task t_reset;
    begin
      rdc(8'h04, 32'h0);
      for (k = 8'h14; k < 8'h20; k = k + 8'h04) rdc(k, 32'h0);
      wr(8'h30, 32'hFFFFFFFF);
      rdc(8'h30, 32'h0);
    end
  endtask
  task t_ptr;
    begin
      wr(8'h08, 32'h3);
      exec(4'h0);
      rdc(8'h08, 32'h7);
      rdc(8'h14, 32'h3C00);
      exec(4'h1);
      rdc(8'h14, 32'h3FFF);
      exec(4'h2);
      exec(4'h3);
      rdc(8'h18, 32'h2001);
      exec(4'h4);
      exec(4'h5);
      rdc(8'h1C, 32'h03AB);
      exec(4'hC);
      exec(4'hD);
      rdc(8'h14, 32'h3FFF);
      rdc(8'h18, 32'h2001);
      rdc(8'h1C, 32'h03AB);
      rdc(8'h08, 32'h3);
    end
  endtask
  task t_move;
    begin
      wr(8'h0C, 32'h5);
      mset(14'h0510, 8'h80);
      mset(14'h0010, 8'h33);
      exec(4'h6);
      rdc(8'h04, 32'h80);
      chk(32'h80, {24'h0, accumulator});
      rdc(8'h08, 32'h2);
      mset(14'h0510, 8'h00);
      exec(4'h7);
      rdc(8'h08, 32'h1);
      rdc(8'h04, 32'h80);
      mset(14'h0022, 8'h22);
      mset(14'h0522, 8'h44);
      wr(8'h04, 32'hFF);
      exec(4'h8);
      rdc(8'h04, 32'h22);
      mset(14'h0085, 8'h11);
      mset(14'h0485, 8'h7F);
      exec(4'h9);
      rdc(8'h04, 32'h7F);
      wr(8'h10, 32'h1);
      mset(14'h0005, 8'hA5);
      mset(14'h03B0, 8'h5A);
      exec(4'hA);
      rdc(8'h04, 32'h5A);
      mset(14'h0060, 8'h3C);
      mset(14'h0460, 8'h96);
      exec(4'hB);
      rdc(8'h04, 32'h96);
      rdc(8'h08, 32'h2);
    end
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset;
    t_ptr;
    t_move;
    summarize;
  end
  // The whole run needs a few hundred bus cycles; this leaves a wide margin
  initial begin
    #200000;
    errors = errors + 1;
    summarize;
  end
endmodule

bind plm_exec plm_exec_sva chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .exec_busy(exec_busy), .accumulator(accumulator));
